// File: hdl/tap_pkg.sv
// constants shared by the test-access-port design files
package tap_pkg;
    // ------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------
    localparam int IR_W = 8;
    localparam logic [7:0] OP_EXTEST = 8'h00;
    localparam logic [7:0] OP_SAMPLE = 8'h01;
    localparam logic [7:0] OP_CLAMP = 8'hfa;
    localparam logic [7:0] OP_HIGHZ = 8'hfc;
    localparam logic [7:0] OP_USERCODE = 8'hfd;
    localparam logic [7:0] OP_IDCODE = 8'hfe;
    localparam logic [7:0] OP_BYPASS = 8'hff;
    localparam logic [7:0] OP_CONFIG = 8'hee;
    // ------------------------------------------------------------
    // vendor-private in-system programming codes (arbitrary)
    // ------------------------------------------------------------
    localparam logic [7:0] OP_ISP_ENABLE = 8'he8;
    localparam logic [7:0] OP_ISP_DISABLE = 8'hf0;
    localparam logic [7:0] OP_ERASE_ALL = 8'hec;
    localparam logic [7:0] OP_PROGRAM = 8'hea;
    localparam logic [7:0] OP_VERIFY = 8'hef;
    localparam logic [7:0] OP_SET_SECURE = 8'hf3;
    localparam logic [7:0] OP_LOAD_USER = 8'hf4;
    // ------------------------------------------------------------
    // capture pattern field positions
    // ------------------------------------------------------------
    localparam int CAP_ISP_BIT = 4;
    localparam int CAP_SEC_BIT = 3;
    localparam logic [7:0] CAP_BASE = 8'h01;
    // ------------------------------------------------------------
    // identification and reset values
    // ------------------------------------------------------------
    localparam int ID_W = 32;
    localparam logic [31:0] USERCODE_RST = 32'hffffffff;
    localparam int DATA_W = 32;
    // ------------------------------------------------------------
    // trigger pulse timing: 300 to 500 ns, aim at the least
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int PULSE_MIN_NS = 300;
    localparam int PULSE_MAX_NS = 500;
    localparam int PULSE_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] PULSE_CNT = 4'(PULSE_CYC);
    // boundary chain length: 8 data outputs, trigger out, 2 inputs
    localparam int BSR_OUTS = 9;
    localparam int BSR_INS = 2;
    localparam int BSR_W = 2 * BSR_OUTS + BSR_INS;
endpackage

// File: hdl/tap_cross_if.sv
// crossing signals between the test-clock logic and the system logic
`timescale 1ns/10ps
interface tap_cross_if;
    logic cfg_toggle; // flips once per trigger request, tck side
    logic isp_level; // programming mode, tck side
    logic isp_sync; // programming mode seen on system clock
    modport tck_side (output cfg_toggle, output isp_level);
    modport sys_side (input cfg_toggle, input isp_level, output isp_sync);
endinterface

// File: hdl/cfg_pulse_gen.sv
// system-clock side: trigger pulse generator and mode synchroniser
`timescale 1ns/10ps
module cfg_pulse_gen (
    input wire logic clk_sys,
    input wire logic rstn,
    tap_cross_if.sys_side xc,
    output logic pulse_low
);
    // ------------------------------------------------------------
    // three-stage synchronisers; change counts when stage 2 and 3 agree
    // ------------------------------------------------------------
    logic [2:0] tog_reg;
    logic [2:0] isp_reg;
    logic tog_seen_reg; // last accepted toggle level
    logic isp_seen_reg;
    logic [3:0] cnt_reg; // remaining low cycles
    wire tog_stable = (tog_reg[1] == tog_reg[2]);
    wire tog_event = tog_stable && (tog_reg[2] != tog_seen_reg);
    wire isp_stable = (isp_reg[1] == isp_reg[2]);

    // synchroniser chains
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tog_reg <= 3'h0;
            isp_reg <= 3'h0;
        end else begin
            tog_reg <= {tog_reg[1:0], xc.cfg_toggle};
            isp_reg <= {isp_reg[1:0], xc.isp_level};
        end
    end

    // accepted levels
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tog_seen_reg <= 1'b0;
            isp_seen_reg <= 1'b0;
        end else begin
            if (tog_stable) begin
                tog_seen_reg <= tog_reg[2];
            end
            if (isp_stable) begin
                isp_seen_reg <= isp_reg[2];
            end
        end
    end

    // single low pulse; a request during a pulse restarts nothing
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cnt_reg <= 4'h0;
        end else if (tog_event && cnt_reg == 4'h0) begin
            cnt_reg <= tap_pkg::PULSE_CNT;
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end

    assign pulse_low = (cnt_reg != 4'h0);
    assign xc.isp_sync = isp_seen_reg;
endmodule

// File: hdl/prom_tap.sv
// test-access port and programming control of the configuration memory
`timescale 1ns/10ps
module prom_tap #(
    parameter logic [31:0] ID_VALUE = 32'h0a5a5a5b, // arbitrary value
    parameter int DATA_PINS = 8
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe_n,
    input wire logic [DATA_PINS-1:0] core_data,
    input wire logic [DATA_PINS-1:0] core_data_oe_n,
    output logic [DATA_PINS-1:0] data_out,
    output logic [DATA_PINS-1:0] data_oe_n,
    input wire logic oe_reset_in,
    input wire logic ce_n_in,
    output logic config_trigger_n,
    output logic config_trigger_oe_n,
    output logic programming_active_flag,
    output logic read_secure,
    output logic verify_ok
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (DATA_PINS != 8) begin : g_bad_width
        $error("boundary chain built for eight data pins");
    end

    // ------------------------------------------------------------
    // tap controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TLR = 4'h0,
        RTI = 4'h1,
        SEL_DR = 4'h2,
        CAP_DR = 4'h3,
        SH_DR = 4'h4,
        EX1_DR = 4'h5,
        PA_DR = 4'h6,
        EX2_DR = 4'h7,
        UPD_DR = 4'h8,
        SEL_IR = 4'h9,
        CAP_IR = 4'ha,
        SH_IR = 4'hb,
        EX1_IR = 4'hc,
        PA_IR = 4'hd,
        EX2_IR = 4'he,
        UPD_IR = 4'hf
    } tap_state_e;

    tap_state_e st_reg; // controller state
    tap_state_e st_next;

    // scan stages
    logic [7:0] ir_sh_reg; // instruction shift stage
    logic [7:0] ir_reg; // active instruction
    logic [31:0] dr_sh_reg; // shared data shift stage
    logic [31:0] user_reg; // user code store
    logic [31:0] pattern_reg; // programmed word stand-in
    logic bypass_reg; // one-bit bypass
    logic [tap_pkg::BSR_W-1:0] bsr_sh_reg; // boundary shift
    logic [tap_pkg::BSR_W-1:0] bsr_upd_reg; // boundary update

    // programming state
    logic isp_reg; // in programming mode
    logic secure_reg; // read security
    logic written_reg; // device holds a pattern
    logic verify_reg; // last verify matched

    // trigger and serial out
    logic cfg_tog_reg; // trigger request toggle
    logic tdo_reg; // falling-edge tdo
    logic tdo_en_reg;
    logic pulse_low;

    tap_cross_if xc ();

    // ------------------------------------------------------------
    // controller next state
    // ------------------------------------------------------------
    always_comb begin
        case (st_reg)
            TLR: st_next = tms ? TLR : RTI;
            RTI: st_next = tms ? SEL_DR : RTI;
            SEL_DR: st_next = tms ? SEL_IR : CAP_DR;
            CAP_DR: st_next = tms ? EX1_DR : SH_DR;
            SH_DR: st_next = tms ? EX1_DR : SH_DR;
            EX1_DR: st_next = tms ? UPD_DR : PA_DR;
            PA_DR: st_next = tms ? EX2_DR : PA_DR;
            EX2_DR: st_next = tms ? UPD_DR : SH_DR;
            UPD_DR: st_next = tms ? SEL_DR : RTI;
            SEL_IR: st_next = tms ? TLR : CAP_IR;
            CAP_IR: st_next = tms ? EX1_IR : SH_IR;
            SH_IR: st_next = tms ? EX1_IR : SH_IR;
            EX1_IR: st_next = tms ? UPD_IR : PA_IR;
            PA_IR: st_next = tms ? EX2_IR : PA_IR;
            EX2_IR: st_next = tms ? UPD_IR : SH_IR;
            UPD_IR: st_next = tms ? SEL_DR : RTI;
            default: st_next = TLR;
        endcase
    end

    // ------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------
    wire op_extest = (ir_reg == tap_pkg::OP_EXTEST);
    wire op_sample = (ir_reg == tap_pkg::OP_SAMPLE);
    wire op_clamp = (ir_reg == tap_pkg::OP_CLAMP);
    wire op_highz = (ir_reg == tap_pkg::OP_HIGHZ);
    wire op_id = (ir_reg == tap_pkg::OP_IDCODE);
    wire op_user = (ir_reg == tap_pkg::OP_USERCODE);
    wire op_erase = (ir_reg == tap_pkg::OP_ERASE_ALL);
    wire op_prog = (ir_reg == tap_pkg::OP_PROGRAM);
    wire op_verify = (ir_reg == tap_pkg::OP_VERIFY);

    wire op_pattern = op_prog || op_verify;
    wire op_bsr = op_extest || op_sample;
    // any other code, including clamp, falls to bypass
    wire op_bypass = !(op_bsr || op_id || op_user || op_pattern);

    // scan state strobes
    wire at_upd_dr = (st_reg == UPD_DR);
    wire at_upd_ir = (st_reg == UPD_IR);
    wire at_cap_dr = (st_reg == CAP_DR);
    wire at_sh_dr = (st_reg == SH_DR);
    wire at_sh_ir = (st_reg == SH_IR);
    // user-code copy refused while secured, else the pattern leaks
    wire load_user_ok = isp_reg && at_upd_ir && !secure_reg
        && (ir_sh_reg == tap_pkg::OP_LOAD_USER);

    // capture pattern with live status
    wire [7:0] ir_capture = tap_pkg::CAP_BASE
        | (8'(isp_reg) << tap_pkg::CAP_ISP_BIT)
        | (8'(secure_reg) << tap_pkg::CAP_SEC_BIT);
    // pattern readout forced to zero when secured
    wire [31:0] read_word = secure_reg ? 32'h0 : pattern_reg;
    wire [31:0] id_word = {ID_VALUE[31:1], 1'b1};
    // data capture source; verify captures zero so nothing leaks
    wire [31:0] dr_capture = op_id ? id_word
        : op_user ? user_reg
        : op_verify ? 32'h0
        : read_word;

    // controller state and instruction registers
    always_ff @(posedge tck) begin
        if (!rstn) begin
            st_reg <= TLR;
            ir_reg <= tap_pkg::OP_IDCODE;
            ir_sh_reg <= 8'h0;
        end else begin
            st_reg <= st_next;
            if (st_reg == TLR) begin
                ir_reg <= tap_pkg::OP_IDCODE;
            end else if (at_upd_ir) begin
                ir_reg <= ir_sh_reg;
            end
            if (st_reg == CAP_IR) begin
                ir_sh_reg <= ir_capture;
            end else if (at_sh_ir) begin
                ir_sh_reg <= {tdi, ir_sh_reg[7:1]};
            end
        end
    end

    // ------------------------------------------------------------
    // data registers: id, user code, pattern and bypass
    // ------------------------------------------------------------
    always_ff @(posedge tck) begin
        if (!rstn) begin
            dr_sh_reg <= 32'h0;
            bypass_reg <= 1'b0;
        end else if (at_cap_dr) begin
            bypass_reg <= 1'b0;
            dr_sh_reg <= dr_capture;
        end else if (at_sh_dr) begin
            bypass_reg <= tdi;
            dr_sh_reg <= {tdi, dr_sh_reg[31:1]};
        end
    end

    // ------------------------------------------------------------
    // boundary cells: per output pin value then enable; inputs one
    // ------------------------------------------------------------
    wire [tap_pkg::BSR_W-1:0] bsr_pins;
    genvar gi;
    for (gi = 0; gi < tap_pkg::BSR_OUTS; gi++) begin : g_cell
        if (gi < DATA_PINS) begin : g_data
            assign bsr_pins[2*gi] = core_data[gi];
            assign bsr_pins[2*gi+1] = core_data_oe_n[gi];
        end else begin : g_trig
            // trigger pin: pulls low while the pulse runs
            assign bsr_pins[2*gi] = pulse_low;
            assign bsr_pins[2*gi+1] = !pulse_low;
        end
    end
    assign bsr_pins[tap_pkg::BSR_W-2] = oe_reset_in;
    assign bsr_pins[tap_pkg::BSR_W-1] = ce_n_in;

    // boundary shift and update
    always_ff @(posedge tck) begin
        if (!rstn) begin
            bsr_sh_reg <= '0;
            bsr_upd_reg <= '1;
        end else begin
            if (at_cap_dr && op_bsr) begin
                bsr_sh_reg <= bsr_pins;
            end else if (at_sh_dr && op_bsr) begin
                bsr_sh_reg <= {tdi, bsr_sh_reg[tap_pkg::BSR_W-1:1]};
            end
            if (at_upd_dr && op_bsr) begin
                bsr_upd_reg <= bsr_sh_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // programming operations; security cleared only by full erase or by reset
    // ------------------------------------------------------------
    always_ff @(posedge tck) begin
        if (!rstn) begin
            isp_reg <= 1'b0;
            secure_reg <= 1'b0;
            written_reg <= 1'b0;
            verify_reg <= 1'b0;
            user_reg <= tap_pkg::USERCODE_RST;
            pattern_reg <= 32'h0;
        end else begin
            if (at_upd_ir && ir_sh_reg == tap_pkg::OP_ISP_ENABLE) begin
                isp_reg <= 1'b1;
            end else if (at_upd_ir && ir_sh_reg == tap_pkg::OP_ISP_DISABLE) begin
                isp_reg <= 1'b0;
            end
            if (isp_reg && at_upd_ir && ir_sh_reg == tap_pkg::OP_ERASE_ALL) begin
                secure_reg <= 1'b0;
                written_reg <= 1'b0;
                pattern_reg <= 32'h0;
                user_reg <= tap_pkg::USERCODE_RST;
            end else if (isp_reg && at_upd_ir && ir_sh_reg == tap_pkg::OP_SET_SECURE) begin
                secure_reg <= 1'b1;
            end else if (isp_reg && at_upd_dr && op_prog) begin
                pattern_reg <= dr_sh_reg;
                written_reg <= 1'b1;
            end else if (load_user_ok) begin
                user_reg <= pattern_reg;
            end
            if (isp_reg && at_upd_dr && op_verify) begin
                verify_reg <= !secure_reg && (dr_sh_reg == pattern_reg);
            end
        end
    end

    // trigger request toggle on config instruction
    always_ff @(posedge tck) begin
        if (!rstn) begin
            cfg_tog_reg <= 1'b0;
        end else if (at_upd_ir && ir_sh_reg == tap_pkg::OP_CONFIG) begin
            cfg_tog_reg <= !cfg_tog_reg;
        end
    end

    // ------------------------------------------------------------
    // tdo on falling edge, enabled in shift states
    // ------------------------------------------------------------
    // serial out bit of the selected data path
    wire dr_bit = op_bsr ? bsr_sh_reg[0]
        : op_bypass ? bypass_reg
        : dr_sh_reg[0];
    wire tdo_next = at_sh_ir ? ir_sh_reg[0] : dr_bit;
    always_ff @(negedge tck) begin
        if (!rstn) begin
            tdo_reg <= 1'b0;
            tdo_en_reg <= 1'b0;
        end else begin
            tdo_reg <= tdo_next;
            tdo_en_reg <= at_sh_ir || at_sh_dr;
        end
    end

    // levels handed to the system-clock side
    assign xc.cfg_toggle = cfg_tog_reg;
    assign xc.isp_level = isp_reg;

    // tck may stop, so pulse timing runs on the system clock

    cfg_pulse_gen u_pulse (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .xc(xc),
        .pulse_low(pulse_low)
    );

    // ------------------------------------------------------------
    // pin drive: programming mode floats pins unless clamped
    // ------------------------------------------------------------
    wire drive_bsr = op_extest || op_clamp;
    // tck-side level floats at once; synced copy covers the lag
    wire in_isp = isp_reg || xc.isp_sync;
    wire float_all = op_highz || (in_isp && !op_clamp);
    // value cells on even positions, enables on odd
    for (gi = 0; gi < DATA_PINS; gi++) begin : g_pin
        assign data_out[gi] = drive_bsr ? bsr_upd_reg[2*gi] : core_data[gi];
        assign data_oe_n[gi] = float_all ? 1'b1 : drive_bsr ? bsr_upd_reg[2*gi+1]
            : core_data_oe_n[gi];
    end
    // trigger cells follow the data pairs
    wire tr_idx_low = bsr_upd_reg[2*DATA_PINS];
    wire tr_idx_en = bsr_upd_reg[2*DATA_PINS+1];
    // open drain: only ever drives low
    assign config_trigger_n = 1'b0;
    assign config_trigger_oe_n = float_all ? 1'b1 : drive_bsr ? (tr_idx_en || tr_idx_low)
        : !pulse_low;
    assign tdo = tdo_reg;
    assign tdo_oe_n = !tdo_en_reg;
    assign programming_active_flag = isp_reg;
    assign read_secure = secure_reg;
    assign verify_ok = verify_reg && written_reg;
endmodule

// File: dv/prom_tap_chk.sv
// assertion checker for the test-access port, bound to its top module
`timescale 1ns/10ps
module prom_tap_chk #(
    parameter int DATA_PINS = 8
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic tck,
    input wire logic [DATA_PINS-1:0] data_oe_n,
    input wire logic config_trigger_n,
    input wire logic config_trigger_oe_n,
    input wire logic programming_active_flag,
    input wire logic read_secure,
    input wire logic verify_ok
);
    // ------------------------------------------------------------
    // helper: length of the current trigger low pulse
    // ------------------------------------------------------------
    logic [3:0] low_cnt_reg; // cycles seen low so far
    logic [3:0] low_cnt_next; // saturates so a stuck pin still fails
    assign low_cnt_next = config_trigger_oe_n ? 4'h0 :
        ((low_cnt_reg == 4'hf) ? 4'hf : low_cnt_reg + 4'h1);
    // counter register, cleared by reset
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            low_cnt_reg <= 4'h0;
        end else begin
            low_cnt_reg <= low_cnt_next;
        end
    end
    // ------------------------------------------------------------
    // trigger and data pins, system clock domain
    // ------------------------------------------------------------
    pulse_len_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(config_trigger_oe_n) |-> (!config_trigger_oe_n) [*3] ##1 config_trigger_oe_n)
        else $error("trigger pulse not three cycles long");
    pulse_cap_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        low_cnt_reg <= 4'h3)
        else $error("trigger held low too long");
    drain_value_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        config_trigger_n == 1'b0)
        else $error("open-drain trigger value not low");
    isp_float_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(programming_active_flag) |-> ##[0:4] (&data_oe_n))
        else $error("data pins not floated in programming mode");
    // ------------------------------------------------------------
    // security and verify, test clock domain
    // ------------------------------------------------------------
    secure_clear_a: assert property (@(posedge tck) disable iff (!rstn)
        $fell(read_secure) |-> programming_active_flag)
        else $error("security bit cleared outside programming");
    secure_set_a: assert property (@(posedge tck) disable iff (!rstn)
        $rose(read_secure) |-> programming_active_flag)
        else $error("security bit set outside programming");
    verify_gate_a: assert property (@(posedge tck) disable iff (!rstn)
        $rose(verify_ok) |-> !read_secure && programming_active_flag)
        else $error("verify passed while inhibited");
    secure_hold_a: assert property (@(posedge tck) disable iff (!rstn)
        !programming_active_flag && !$past(programming_active_flag) |-> $stable(read_secure))
        else $error("security bit changed in normal mode");
endmodule

bind prom_tap prom_tap_chk #(.DATA_PINS(DATA_PINS)) chk (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .tck(tck),
    .data_oe_n(data_oe_n),
    .config_trigger_n(config_trigger_n),
    .config_trigger_oe_n(config_trigger_oe_n),
    .programming_active_flag(programming_active_flag),
    .read_secure(read_secure),
    .verify_ok(verify_ok)
);

// File: dv/jtag_host.sv
// behavioural test-port host: clocks, mode select and serial data
`timescale 1ns/10ps
module jtag_host (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe_n
);
    logic tdo_line; // level on the serial-out wire
    // pull-up wins when the device lets go of the wire
    assign tdo_line = tdo_oe_n ? 1'b1 : tdo;
    // idle levels follow the pull-ups; clock stands still
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // one test-clock period; serial out taken at the rising edge
    task automatic step(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        #7.5;
        q = tdo_line;
        tck <= 1'b1;
        #7.5;
        tck <= 1'b0;
    endtask
    // reset frame: mode select high for six clocks
    task automatic tlr();
        logic q;
        for (int i = 0; i < 6; i++) begin
            step(1'b1, 1'b1, q);
        end
    endtask
    // full scan from idle back to idle, lsb first
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        dout = 32'h0;
        step(1'b1, 1'b1, q); // towards the scan column
        if (ir) begin
            step(1'b1, 1'b1, q); // instruction column
        end
        step(1'b0, 1'b1, q); // capture
        step(1'b0, 1'b1, q); // into shift
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b1, q); // update
        step(1'b0, 1'b1, q); // idle, clock then stops
    endtask
endmodule

// File: dv/prom_tap_tb.sv
// self-checking bench for the test-access port and programming control
`timescale 1ns/10ps
`define CHECK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end
module prom_tap_tb;
    localparam logic [31:0] ID_SET = 32'h12345670; // arbitrary, lsb left clear
    localparam logic [31:0] PATTERN = 32'h3c5a9617; // stored pattern
    logic clk_sys, rstn, tck, tms, tdi, tdo, tdo_oe_n, q;
    logic [7:0] core_data, core_data_oe_n, data_out, data_oe_n, cap;
    logic oe_reset_in, ce_n_in, config_trigger_n, config_trigger_oe_n;
    logic programming_active_flag, read_secure, verify_ok;
    logic [31:0] rd; // last scanned-out value
    logic [3:0] lowc; // trigger low cycles seen
    int err_count, comparisons;
    prom_tap #(.ID_VALUE(ID_SET)) dut (
        .clk_sys(clk_sys), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n), .core_data(core_data), .core_data_oe_n(core_data_oe_n),
        .data_out(data_out), .data_oe_n(data_oe_n), .oe_reset_in(oe_reset_in),
        .ce_n_in(ce_n_in), .config_trigger_n(config_trigger_n),
        .config_trigger_oe_n(config_trigger_oe_n),
        .programming_active_flag(programming_active_flag),
        .read_secure(read_secure), .verify_ok(verify_ok));
    jtag_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
    // ------------------------------------------------------------
    // clock and access tasks
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // instruction scan; capture pattern kept in cap
    task automatic ir(input logic [7:0] code);
        host.scan(1'b1, 8, {24'h0, code}, rd);
        cap = rd[7:0];
    endtask
    // data scan of n bits
    task automatic dr(input int n, input logic [31:0] din);
        host.scan(1'b0, n, din, rd);
    endtask
    // mode changes cross to the system clock; let them land
    task automatic settle();
        repeat (5) @(posedge clk_sys);
    endtask
    // boundary image: value/enable pairs, then trigger, then inputs
    function automatic logic [19:0] bsr(input logic [7:0] d, input logic [7:0] oe,
                                        input logic [3:0] tail);
        logic [19:0] v;
        for (int k = 0; k < 8; k++) begin
            v[2*k] = d[k];
            v[2*k+1] = oe[k];
        end
        v[19:16] = tail;
        return v;
    endfunction
    task automatic end_of_test();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // watchdog: the tests need well under a tenth of this
    initial begin
        #2000000;
        err_count++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        err_count = 0;
        comparisons = 0;
        rstn = 1'b0;
        core_data = 8'h5a;
        core_data_oe_n = 8'h0f;
        oe_reset_in = 1'b1;
        ce_n_in = 1'b0;
        fork
            host.tlr();
        join_none
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        host.step(1'b0, 1'b1, q);
        dr(32, 32'h0);
        `CHECK(rd, ID_SET | 32'h1)
        ir(tap_pkg::OP_SAMPLE);
        `CHECK(cap, 8'h01)
        dr(20, {12'h0, bsr(8'hc3, 8'h00, 4'h2)});
        `CHECK(rd[19:0], bsr(8'h5a, 8'h0f, 4'h6))
        ir(tap_pkg::OP_EXTEST);
        `CHECK({data_out, data_oe_n}, 16'hc300)
        ir(tap_pkg::OP_HIGHZ);
        `CHECK(data_oe_n, 8'hff)
        ir(tap_pkg::OP_CLAMP);
        `CHECK({data_out, data_oe_n}, 16'hc300)
        for (int i = 0; i < 3; i++) begin
            ir(i == 0 ? tap_pkg::OP_CLAMP : (i == 1 ? tap_pkg::OP_BYPASS : 8'h55));
            `CHECK(cap, 8'h01)
            dr(2, 32'h1);
            `CHECK(rd[1:0], 2'b10)
        end
        `CHECK(data_out, 8'h5a)
        ir(tap_pkg::OP_USERCODE);
        dr(32, 32'h0);
        `CHECK(rd, 32'hffffffff)
        ir(tap_pkg::OP_IDCODE);
        dr(32, 32'h0);
        `CHECK(rd, ID_SET | 32'h1)
        for (int i = 0; i < 2; i++) begin
            ir(tap_pkg::OP_CONFIG);
            lowc = 4'h0;
            repeat (14) begin
                @(posedge clk_sys);
                #1;
                lowc = lowc + {3'h0, !config_trigger_oe_n};
            end
            `CHECK(lowc, 4'h3)
        end
        @(posedge clk_sys);
        oe_reset_in <= 1'b0;
        ir(tap_pkg::OP_ISP_ENABLE);
        settle();
        `CHECK({programming_active_flag, data_oe_n}, 9'h1ff)
        ir(tap_pkg::OP_PROGRAM);
        `CHECK(cap, 8'h11)
        dr(32, PATTERN);
        ir(tap_pkg::OP_VERIFY);
        dr(32, PATTERN);
        `CHECK(verify_ok, 1'b1)
        ir(tap_pkg::OP_LOAD_USER);
        ir(tap_pkg::OP_USERCODE);
        dr(32, 32'h0);
        `CHECK(rd, PATTERN)
        ir(tap_pkg::OP_SET_SECURE);
        ir(tap_pkg::OP_VERIFY);
        `CHECK(cap, 8'h19)
        dr(32, PATTERN);
        `CHECK({rd, verify_ok}, 33'h0)
        ir(tap_pkg::OP_PROGRAM);
        dr(32, ~PATTERN);
        `CHECK(rd, 32'h0)
        ir(tap_pkg::OP_LOAD_USER);
        ir(tap_pkg::OP_USERCODE);
        dr(32, 32'h0);
        `CHECK(rd, PATTERN)
        ir(tap_pkg::OP_ISP_DISABLE);
        ir(tap_pkg::OP_ISP_ENABLE);
        `CHECK(read_secure, 1'b1)
        ir(tap_pkg::OP_ERASE_ALL);
        ir(tap_pkg::OP_USERCODE);
        `CHECK({cap, read_secure}, 9'h022)
        dr(32, 32'h0);
        `CHECK(rd, 32'hffffffff)
        ir(tap_pkg::OP_ISP_DISABLE);
        ir(tap_pkg::OP_BYPASS);
        `CHECK({cap, programming_active_flag}, 9'h002)
        @(posedge clk_sys);
        oe_reset_in <= 1'b1;
        settle();
        end_of_test();
    end
endmodule
